//--- verilog/sssef_pkg.sv
// How it works
// [RULE1] Zero first stop bit sets framing error flag
// [RULE2] With two stop bits, check first only
// [RULE3] Framing error loads receive holding, not full flag
// [RULE4] Framing error halts receive; synchronous also transmit
// [RULE5] Framing flag clears: reset, standby, read-then-zero
// [RULE6] Receiver off leaves framing flag unchanged
// [RULE7] Smart-card mode: bit four is error signal
// [RULE8] Smart card: low returned error signal sets flag
// [RULE9] Error signal flag clears like others; transmitter-off keeps
// [RULE10] Async parity mismatch against odd select sets flag
// [RULE11] Parity flag clears: reset, standby, read-then-zero
// [RULE12] Parity error loads data, no full, halts
// [RULE13] Normal end flag: reset, transmitter off, last bit
// [RULE14] End flag read-only, cleared with transmit empty
// [RULE15] Smart end flag 2.5 or 1.0 etu later
// [RULE16] Smart end flag on transmitter off without error
// [RULE17] One etu is one bit time
// [RULE18] Async multiprocessor bit captured, read-only, resets zero
// [RULE19] Receiver off holds received multiprocessor bit
// [RULE20] Transmit multiprocessor bit used only when applicable
// [RULE21] Writing one to clearable flags does nothing
// [RULE22] Hardware set between read and write wins
package sssef_pkg;

	localparam int         AW            = 8;       // Bus address width
	localparam logic [7:0] OFS_STATUS    = 8'h00;   // serial_status
	localparam logic [7:0] OFS_CONTROL   = 8'h04;   // Mode and enable bits
	localparam logic [7:0] OFS_ETU       = 8'h08;   // Clock cycles per bit
	localparam logic [7:0] OFS_RXDATA    = 8'h0c;   // receive_holding
	localparam logic [7:0] OFS_TXDATA    = 8'h10;   // transmit_holding

	// serial_status bit positions
	localparam int ST_TRANSMIT_EMPTY_FLAG = 7;
	localparam int ST_RECEIVE_FULL_FLAG = 6;
	localparam int ST_OVERRUN_FLAG = 5;
	localparam int ST_FER  = 4;
	localparam int ST_PER  = 3;
	localparam int ST_TRANSMIT_END_FLAG = 2;
	localparam int ST_MPB  = 1;
	localparam int ST_TX_MULTIPROC_BIT = 0;

	// Control register bit positions
	localparam int CT_TX_ON  = 0;
	localparam int CT_RX_ON  = 1;
	localparam int CT_SMART  = 2;
	localparam int CT_GM     = 3;
	localparam int CT_SYNC   = 4;
	localparam int CT_MP     = 5;
	localparam int CT_PAR_EN = 6;
	localparam int CT_ODD    = 7;

	localparam logic [7:0]  STATUS_RESET  = 8'h84;   // Empty and end set
	localparam logic [7:0]  CONTROL_RESET = 8'h00;   // All off
	localparam logic [15:0] ETU_RESET     = 16'h0174; // Default bit time
	localparam logic [2:0]  HALF_ETU_GM0  = 3'h5;    // 2.5 etu in half etus
	localparam logic [2:0]  HALF_ETU_GM1  = 3'h2;    // 1.0 etu in half etus
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// Receive shift path event
	typedef struct packed {
		logic       done;     // Character ended, one cycle
		logic [7:0] data;     // Received character
		logic       parity;   // Received parity bit
		logic [1:0] stop;     // Stop bits, first in bit 0
		logic       rx_multiproc_bit;      // Received multiprocessor bit
	} sssef_rx_ev_t;

	// Transmit shift path event
	typedef struct packed {
		logic load;           // Holding moved to shifter, one cycle
		logic last_bit;       // Last bit of character sent, one cycle
		logic err_sample;     // Error signal sampled now, one cycle
		logic err_level;      // Sampled error signal level
	} sssef_tx_ev_t;

	// End-flag delay timer
	typedef enum logic [1:0] {
		TM_IDLE = 2'b01,
		TM_WAIT = 2'b10
	} sssef_tm_t;

	// Whole block state
	typedef struct packed {
		logic        transmit_empty_flag, receive_full_flag, overrun_flag, framing_error_flag, parity_error_flag, transmit_end_flag, rx_multiproc_bit, tx_multiproc_bit;
		logic [4:0]  armed;     // Flags read as one: transmit_empty_flag,receive_full_flag,overrun_flag,fer,per
		logic [7:0]  ctrl;
		logic [15:0] etu;
		logic [7:0]  rx_hold;
		logic [7:0]  tx_hold;
		sssef_tm_t   tm;
		logic [15:0] pre_cnt;
		logic [2:0]  half_cnt;
		logic        awready, wready, arready, bvalid, rvalid;
		logic [1:0]  bresp, rresp;
		logic [31:0] rdata;
		logic        aw_held, w_held;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        rx_en, tx_en, tx_mpb_use;
	} sssef_state_t;

endpackage

//--- verilog/sssef_top.sv
`timescale 1ns/100ps
module sssef_top #(
	parameter logic [15:0] ETU_DEFAULT = sssef_pkg::ETU_RESET // Bit time after reset
) (
	input  wire logic                  CLK,
	input  wire logic                  RESET_N,
	input  wire logic                  STANDBY,
	input  wire logic [7:0]            S_AXI_AWADDR,
	input  wire logic                  S_AXI_AWVALID,
	output logic                       S_AXI_AWREADY,
	input  wire logic [31:0]           S_AXI_WDATA,
	input  wire logic [3:0]            S_AXI_WSTRB,
	input  wire logic                  S_AXI_WVALID,
	output logic                       S_AXI_WREADY,
	output logic [1:0]                 S_AXI_BRESP,
	output logic                       S_AXI_BVALID,
	input  wire logic                  S_AXI_BREADY,
	input  wire logic [7:0]            S_AXI_ARADDR,
	input  wire logic                  S_AXI_ARVALID,
	output logic                       S_AXI_ARREADY,
	output logic [31:0]                S_AXI_RDATA,
	output logic [1:0]                 S_AXI_RRESP,
	output logic                       S_AXI_RVALID,
	input  wire logic                  S_AXI_RREADY,
	input  wire sssef_pkg::sssef_rx_ev_t RX_EV,
	input  wire sssef_pkg::sssef_tx_ev_t TX_EV,
	output logic                       RX_ENABLE,
	output logic                       TX_ENABLE,
	output logic [7:0]                 TX_HOLD,
	output logic                       TX_FULL,
	output logic                       TX_MPB,
	output logic                       TX_MPB_USE
);

	sssef_pkg::sssef_state_t s_reg;       // Current state
	sssef_pkg::sssef_state_t s_next;      // Next state
	sssef_pkg::sssef_state_t s_rst;       // Reset image

	logic        smart;                   // Smart-card mode
	logic        sync_m;                  // Synchronous mode
	logic        mp_fmt;                  // Multiprocessor format
	logic        rx_ok;                   // Accepted receive event
	logic        fer_set, per_set, ers_set, err_rx;
	logic        receive_full_flag_set, overrun_flag_set, transmit_empty_flag_set;
	logic        transmit_end_flag_set, te_fall;
	logic        wr_fire, wr_status, rd_fire;
	logic [4:0]  clr;                     // Software clear per flag
	logic [4:0]  cur;                     // Flags as read, armed order
	logic [4:0]  setv;                    // Hardware set per flag
	logic [7:0]  wd8;                     // Low write byte
	logic [7:0]  new_ctrl;                // Control after write
	logic [15:0] half_period;             // Cycles per half etu
	logic [2:0]  half_target;             // Half etus to wait
	logic        tm_done;                 // Delay elapsed pulse
	logic        blk;                     // Errors that block reception

	// Flag with set winning over clear
	function automatic logic flag_next(input logic cur_v, input logic set_v, input logic clr_v);
		return set_v | (cur_v & ~clr_v);
	endfunction

	// Status byte as software sees it
	function automatic logic [7:0] status_byte(input sssef_pkg::sssef_state_t st);
		return {st.transmit_empty_flag, st.receive_full_flag, st.overrun_flag, st.framing_error_flag, st.parity_error_flag, st.transmit_end_flag, st.rx_multiproc_bit, st.tx_multiproc_bit};
	endfunction

	// Reset image of the whole state
	always_comb begin
		s_rst          = '0;
		s_rst.transmit_empty_flag     = sssef_pkg::STATUS_RESET[sssef_pkg::ST_TRANSMIT_EMPTY_FLAG];
		s_rst.transmit_end_flag     = sssef_pkg::STATUS_RESET[sssef_pkg::ST_TRANSMIT_END_FLAG];
		s_rst.ctrl     = sssef_pkg::CONTROL_RESET;
		s_rst.etu      = ETU_DEFAULT;
		s_rst.tm       = sssef_pkg::TM_IDLE;
		s_rst.awready  = 1'b1;
		s_rst.wready   = 1'b1;
		s_rst.arready  = 1'b1;
	end

	// Next-state logic
	always_comb begin
		s_next  = s_reg;
		smart   = s_reg.ctrl[sssef_pkg::CT_SMART];
		sync_m  = s_reg.ctrl[sssef_pkg::CT_SYNC];
		mp_fmt  = s_reg.ctrl[sssef_pkg::CT_MP];
		wd8     = s_reg.wdata[7:0];
		tm_done = 1'b0;

		// Bus write fires once address and data are both held
		wr_fire   = s_reg.aw_held & s_reg.w_held & ~s_reg.bvalid;
		wr_status = wr_fire & s_reg.wstrb[0] & (s_reg.awaddr == sssef_pkg::OFS_STATUS);
		rd_fire   = S_AXI_ARVALID & s_reg.arready;
		new_ctrl  = s_reg.ctrl;
		if (wr_fire && s_reg.wstrb[0] && s_reg.awaddr == sssef_pkg::OFS_CONTROL) begin
			new_ctrl = wd8;
		end
		te_fall = s_reg.ctrl[sssef_pkg::CT_TX_ON] & ~new_ctrl[sssef_pkg::CT_TX_ON];

		// Receive events count only while reception is allowed
		rx_ok    = RX_EV.done & s_reg.rx_en; // RULE4
		// Only the first stop bit is looked at
		fer_set  = rx_ok & ~smart & ~sync_m & ~RX_EV.stop[0]; // RULE1 RULE2 RULE7
		per_set  = rx_ok & ~sync_m & s_reg.ctrl[sssef_pkg::CT_PAR_EN]
			& ((^{RX_EV.data, RX_EV.parity}) != s_reg.ctrl[sssef_pkg::CT_ODD]); // RULE10
		err_rx   = fer_set | per_set;
		receive_full_flag_set = rx_ok & ~err_rx & ~s_reg.receive_full_flag; // RULE3 RULE12
		overrun_flag_set = rx_ok & ~err_rx & s_reg.receive_full_flag;
		// Returned error signal low during smart-card transmission
		ers_set  = smart & TX_EV.err_sample & ~TX_EV.err_level; // RULE8
		transmit_empty_flag_set = TX_EV.load | te_fall;

		// Character into receive holding, also on parity or framing error
		if (rx_ok && !overrun_flag_set) begin
			s_next.rx_hold = RX_EV.data; // RULE3 RULE12
			if (!sync_m && mp_fmt) begin
				s_next.rx_multiproc_bit = RX_EV.rx_multiproc_bit; // RULE18 RULE19
			end
		end

		// Smart-card end delay, counted in half etus
		half_period = (s_reg.etu >> 1) == 16'h0000 ? 16'h0001 : (s_reg.etu >> 1); // RULE17
		half_target = s_reg.ctrl[sssef_pkg::CT_GM] ? sssef_pkg::HALF_ETU_GM1 : sssef_pkg::HALF_ETU_GM0;
		case (s_reg.tm)
			sssef_pkg::TM_IDLE: begin
				if (smart && TX_EV.last_bit) begin
					s_next.tm       = sssef_pkg::TM_WAIT;
					s_next.pre_cnt  = half_period - 16'h0001;
					s_next.half_cnt = 3'h0;
				end
			end
			sssef_pkg::TM_WAIT: begin
				if (s_reg.pre_cnt == 16'h0000) begin
					// Half-etu tick from the divider
					s_next.pre_cnt  = half_period - 16'h0001;
					s_next.half_cnt = s_reg.half_cnt + 3'h1;
					if (s_reg.half_cnt + 3'h1 >= half_target) begin
						tm_done   = 1'b1; // RULE15
						s_next.tm = sssef_pkg::TM_IDLE;
					end
				end else begin
					s_next.pre_cnt = s_reg.pre_cnt - 16'h0001;
				end
			end
			default: begin
				s_next.tm = sssef_pkg::TM_IDLE;
			end
		endcase

		// End flag setting conditions per mode
		if (smart) begin
			transmit_end_flag_set = (tm_done & s_reg.transmit_empty_flag & ~s_reg.framing_error_flag) | (te_fall & ~s_reg.framing_error_flag); // RULE15 RULE16
		end else begin
			transmit_end_flag_set = (TX_EV.last_bit & s_reg.transmit_empty_flag) | te_fall; // RULE13
		end

		// Software clears: only a zero written after a read of one
		cur  = {s_reg.transmit_empty_flag, s_reg.receive_full_flag, s_reg.overrun_flag, s_reg.framing_error_flag, s_reg.parity_error_flag};
		setv = {transmit_empty_flag_set, receive_full_flag_set, overrun_flag_set, fer_set | ers_set, per_set};
		clr  = {5{wr_status}} & s_reg.armed & ~{wd8[sssef_pkg::ST_TRANSMIT_EMPTY_FLAG], wd8[sssef_pkg::ST_RECEIVE_FULL_FLAG],
			wd8[sssef_pkg::ST_OVERRUN_FLAG], wd8[sssef_pkg::ST_FER], wd8[sssef_pkg::ST_PER]}; // RULE21
		s_next.transmit_empty_flag = flag_next(s_reg.transmit_empty_flag, setv[4], clr[4]);
		s_next.receive_full_flag = flag_next(s_reg.receive_full_flag, setv[3], clr[3]);
		s_next.overrun_flag = flag_next(s_reg.overrun_flag, setv[2], clr[2]);
		// Bit four is framing or error signal; receiver/transmitter off keep it
		s_next.framing_error_flag  = flag_next(s_reg.framing_error_flag, setv[1], clr[1]); // RULE5 RULE6 RULE9 RULE22
		s_next.parity_error_flag  = flag_next(s_reg.parity_error_flag, setv[0], clr[0]); // RULE11 RULE22
		// End flag follows a real software clear of the empty flag
		s_next.transmit_end_flag = flag_next(s_reg.transmit_end_flag, transmit_end_flag_set, clr[4] & ~setv[4]); // RULE14

		// Arm on a read of one; disarm on any status write or a new set
		s_next.armed = s_reg.armed & ~setv; // RULE22
		if (wr_status) begin
			s_next.armed = 5'h00;
		end
		if (rd_fire && S_AXI_ARADDR == sssef_pkg::OFS_STATUS) begin
			s_next.armed = s_next.armed | (cur & ~setv);
		end

		// Register writes and write response
		if (wr_fire) begin
			s_next.bvalid  = 1'b1;
			s_next.aw_held = 1'b0;
			s_next.w_held  = 1'b0;
			s_next.bresp   = sssef_pkg::RESP_OKAY;
			case (s_reg.awaddr)
				sssef_pkg::OFS_STATUS: begin
					if (s_reg.wstrb[0]) begin
						s_next.tx_multiproc_bit = wd8[sssef_pkg::ST_TX_MULTIPROC_BIT];
					end
				end
				sssef_pkg::OFS_CONTROL: begin
					s_next.ctrl = new_ctrl;
				end
				sssef_pkg::OFS_ETU: begin
					if (s_reg.wstrb[0]) begin
						s_next.etu[7:0] = wd8;
					end
					if (s_reg.wstrb[1]) begin
						s_next.etu[15:8] = s_reg.wdata[15:8];
					end
				end
				sssef_pkg::OFS_RXDATA: begin
					s_next.bresp = sssef_pkg::RESP_OKAY;
				end
				sssef_pkg::OFS_TXDATA: begin
					if (s_reg.wstrb[0]) begin
						s_next.tx_hold = wd8;
					end
				end
				default: begin
					s_next.bresp = sssef_pkg::RESP_SLVERR;
				end
			endcase
		end

		// Write address and data channels, taken in either order
		if (S_AXI_AWVALID && s_reg.awready) begin
			s_next.awready = 1'b0;
			s_next.aw_held = 1'b1;
			s_next.awaddr  = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && s_reg.wready) begin
			s_next.wready = 1'b0;
			s_next.w_held = 1'b1;
			s_next.wdata  = S_AXI_WDATA;
			s_next.wstrb  = S_AXI_WSTRB;
		end
		if (s_reg.bvalid && S_AXI_BREADY) begin
			s_next.bvalid  = 1'b0;
			s_next.awready = 1'b1;
			s_next.wready  = 1'b1;
		end

		// Read channel, answered on the edge that takes the address
		if (rd_fire) begin
			s_next.arready = 1'b0;
			s_next.rvalid  = 1'b1;
			s_next.rresp   = sssef_pkg::RESP_OKAY;
			s_next.rdata   = 32'h00000000;
			case (S_AXI_ARADDR)
				sssef_pkg::OFS_STATUS: begin
					s_next.rdata[7:0] = status_byte(s_reg);
				end
				sssef_pkg::OFS_CONTROL: begin
					s_next.rdata[7:0] = s_reg.ctrl;
				end
				sssef_pkg::OFS_ETU: begin
					s_next.rdata[15:0] = s_reg.etu;
				end
				sssef_pkg::OFS_RXDATA: begin
					s_next.rdata[7:0] = s_reg.rx_hold;
				end
				sssef_pkg::OFS_TXDATA: begin
					s_next.rdata[7:0] = s_reg.tx_hold;
				end
				default: begin
					s_next.rresp = sssef_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (s_reg.rvalid && S_AXI_RREADY) begin
			s_next.rvalid  = 1'b0;
			s_next.arready = 1'b1;
		end

		// Standby brings status and timer back to their reset image
		if (STANDBY) begin
			s_next.transmit_empty_flag  = s_rst.transmit_empty_flag; // RULE5 RULE9 RULE11 RULE13 RULE16
			s_next.receive_full_flag  = 1'b0;
			s_next.overrun_flag  = 1'b0;
			s_next.framing_error_flag   = 1'b0;
			s_next.parity_error_flag   = 1'b0;
			s_next.transmit_end_flag  = s_rst.transmit_end_flag;
			s_next.rx_multiproc_bit   = 1'b0;
			s_next.tx_multiproc_bit  = 1'b0;
			s_next.armed = 5'h00;
			s_next.tm    = sssef_pkg::TM_IDLE;
		end

		// Enables seen by the shift paths
		blk = (s_next.framing_error_flag & ~s_next.ctrl[sssef_pkg::CT_SMART]) | s_next.parity_error_flag | s_next.overrun_flag;
		s_next.rx_en = s_next.ctrl[sssef_pkg::CT_RX_ON] & ~blk; // RULE4 RULE12
		s_next.tx_en = s_next.ctrl[sssef_pkg::CT_TX_ON]
			& ~(s_next.ctrl[sssef_pkg::CT_SYNC] & blk); // RULE4 RULE12
		s_next.tx_mpb_use = s_next.tx_en & ~s_next.ctrl[sssef_pkg::CT_SYNC]
			& s_next.ctrl[sssef_pkg::CT_MP]; // RULE20
	end

	// State register, synchronous reset
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			s_reg <= s_rst;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from state flops
	assign S_AXI_AWREADY = s_reg.awready;
	assign S_AXI_WREADY  = s_reg.wready;
	assign S_AXI_BVALID  = s_reg.bvalid;
	assign S_AXI_BRESP   = s_reg.bresp;
	assign S_AXI_ARREADY = s_reg.arready;
	assign S_AXI_RVALID  = s_reg.rvalid;
	assign S_AXI_RDATA   = s_reg.rdata;
	assign S_AXI_RRESP   = s_reg.rresp;
	assign RX_ENABLE     = s_reg.rx_en;
	assign TX_ENABLE     = s_reg.tx_en;
	assign TX_HOLD       = s_reg.tx_hold;
	assign TX_FULL       = ~s_reg.transmit_empty_flag;
	assign TX_MPB        = s_reg.tx_multiproc_bit;
	assign TX_MPB_USE    = s_reg.tx_mpb_use;

endmodule

//--- sim/sssef_chk.sv
`timescale 1ns/100ps
// Port-level checks on the bus handshake and flag images
module sssef_chk (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic STANDBY,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic RX_ENABLE,
	input wire logic TX_ENABLE,
	input wire logic TX_FULL
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);
	// Both write channels taken at one edge
	sequence s_wr_taken;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	// Internal fire cycle, then the response
	sequence s_wr_resp;
		!S_AXI_BVALID ##1 S_AXI_BVALID;
	endsequence
	a_wr_resp_time: assert property (s_wr_taken |=> s_wr_resp)
		else $error("write response timing wrong");
	a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read data not given");
	a_rd_reopen: assert property (S_AXI_RVALID && S_AXI_RREADY |=> S_AXI_ARREADY && !S_AXI_RVALID)
		else $error("read channel not reopened");
	a_wr_reopen: assert property (S_AXI_BVALID && S_AXI_BREADY |=> S_AXI_AWREADY && S_AXI_WREADY && !S_AXI_BVALID)
		else $error("write channel not reopened");
	a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("second read accepted");
	a_full_by_write: assert property ($rose(TX_FULL) |-> $rose(S_AXI_BVALID))
		else $error("empty flag cleared outside a write");
	a_standby_empty: assert property (STANDBY |=> !TX_FULL)
		else $error("standby left holding full");
	a_reset_image: assert property ($rose(RESET_N) |-> !TX_FULL && !RX_ENABLE && !TX_ENABLE)
		else $error("reset image wrong");
endmodule
bind sssef_top sssef_chk u_chk (.CLK, .RESET_N, .STANDBY, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
	.S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID,
	.S_AXI_RREADY, .RX_ENABLE, .TX_ENABLE, .TX_FULL);

//--- sim/sssef_peer.sv
`timescale 1ns/100ps
// Far-side serial peer: shift path events, one cycle each
module sssef_peer (
	input  wire logic             clk,
	output sssef_pkg::sssef_rx_ev_t rx_ev,
	output sssef_pkg::sssef_tx_ev_t tx_ev
);
	// Idle: no events, error line high
	initial begin
		rx_ev = '0;
		tx_ev = 4'h1;
	end
	// One received character
	task automatic send_char(input logic [7:0] d, input logic p, input logic [1:0] s, input logic m);
		rx_ev <= {1'b1, d, p, s, m};
		@(posedge clk);
		rx_ev <= {1'b0, ~d, ~p, ~s, ~m}; // Payload not held after done
	endtask
	// One transmit pulse: load 9, last bit 5, error low 2
	// An idle edge follows so a second pulse never lands in the release step
	task automatic tx_pulse(input logic [3:0] v);
		tx_ev <= v;
		@(posedge clk);
		tx_ev <= 4'h1;
		@(posedge clk);
	endtask
endmodule

//--- sim/test_serial_status_error_flags.sv
`timescale 1ns/100ps
module test_serial_status_error_flags;
	logic                    CLK, RESET_N, STANDBY;
	logic [7:0]              S_AXI_AWADDR, S_AXI_ARADDR, TX_HOLD;
	logic [31:0]             S_AXI_WDATA, S_AXI_RDATA, q;
	logic [3:0]              S_AXI_WSTRB;
	logic [1:0]              S_AXI_BRESP, S_AXI_RRESP, r;
	logic                    S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
	logic                    S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
	logic                    RX_ENABLE, TX_ENABLE, TX_FULL, TX_MPB, TX_MPB_USE;
	sssef_pkg::sssef_rx_ev_t RX_EV;
	sssef_pkg::sssef_tx_ev_t TX_EV;
	int                      fail_count, checks;
	// Bit time shortened to four cycles
	sssef_top #(.ETU_DEFAULT(16'h0004)) DUT (.CLK, .RESET_N, .STANDBY, .S_AXI_AWADDR, .S_AXI_AWVALID,
		.S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
		.S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
		.S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .RX_EV, .TX_EV, .RX_ENABLE, .TX_ENABLE, .TX_HOLD,
		.TX_FULL, .TX_MPB, .TX_MPB_USE);
	sssef_peer peer (.clk(CLK), .rx_ev(RX_EV), .tx_ev(TX_EV));
	// 250 MHz clock
	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Counts, verdict, end of run
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// One bus access; each channel released when taken; response readies stay high
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		if (w) begin
			S_AXI_AWADDR <= a;
			S_AXI_WDATA <= d;
			S_AXI_AWVALID <= 1'b1;
			S_AXI_WVALID <= 1'b1;
		end else begin
			S_AXI_ARADDR <= a;
			S_AXI_ARVALID <= 1'b1;
		end
		repeat (40) begin
			@(posedge CLK);
			if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
			if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
			if (S_AXI_BREADY && S_AXI_BVALID) begin
				r = S_AXI_BRESP;
				return;
			end
			if (S_AXI_RREADY && S_AXI_RVALID) begin
				r = S_AXI_RRESP;
				q = S_AXI_RDATA;
				return;
			end
		end
		fail_count++;
		$display("unexpected at %0t: bus timeout", $time);
		tally_and_finish;
	endtask
	// Read and compare
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	// Main sequence
	initial begin
		{RESET_N, STANDBY, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID} = '0;
		S_AXI_BREADY = 1'b1;
		S_AXI_RREADY = 1'b1;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
		S_AXI_WSTRB = 4'hf;
		fail_count = 0;
		checks = 0;
		repeat (20) @(posedge CLK);
		RESET_N <= 1'b1;
		@(posedge CLK);
		rd(8'h00, 32'h84);
		acc(1'b0, 8'h14, 32'h0);
		chk({30'h0, r}, 32'h2);
		// Second stop bit low is not checked
		acc(1'b1, 8'h04, 32'h02);
		peer.send_char(8'h33, 1'b0, 2'b01, 1'b0);
		rd(8'h00, 32'hc4);
		acc(1'b1, 8'h00, 32'hbe);
		// First stop bit low: framing error
		peer.send_char(8'h5a, 1'b0, 2'b10, 1'b0);
		rd(8'h00, 32'h94);
		rd(8'h0c, 32'h5a);
		chk({31'h0, RX_ENABLE}, 32'h0);
		// Synchronous mode: pending framing error also stops the transmitter
		acc(1'b1, 8'h04, 32'h13);
		chk({31'h0, TX_ENABLE}, 32'h0);
		peer.send_char(8'h11, 1'b0, 2'b11, 1'b0);
		rd(8'h0c, 32'h5a);
		acc(1'b1, 8'h00, 32'hfe);
		acc(1'b1, 8'h04, 32'h00);
		acc(1'b1, 8'h00, 32'hee);
		rd(8'h00, 32'h94);
		acc(1'b1, 8'h00, 32'hee);
		rd(8'h00, 32'h84);
		// Parity, odd then even
		acc(1'b1, 8'h04, 32'hc2);
		peer.send_char(8'h01, 1'b1, 2'b11, 1'b0);
		rd(8'h00, 32'h8c);
		rd(8'h0c, 32'h01);
		acc(1'b1, 8'h04, 32'h40);
		rd(8'h00, 32'h8c);
		acc(1'b1, 8'h00, 32'hf6);
		acc(1'b1, 8'h04, 32'h42);
		peer.send_char(8'h01, 1'b1, 2'b11, 1'b0);
		rd(8'h00, 32'hc4);
		acc(1'b1, 8'h00, 32'hbe);
		// Normal end of transmission
		acc(1'b1, 8'h04, 32'h01);
		acc(1'b1, 8'h10, 32'ha5);
		rd(8'h00, 32'h84);
		acc(1'b1, 8'h00, 32'h7e);
		rd(8'h00, 32'h00);
		chk({23'h0, TX_FULL, TX_HOLD}, 32'h1a5);
		peer.tx_pulse(4'h9);
		peer.tx_pulse(4'h5);
		rd(8'h00, 32'h84);
		// Smart card: end flag 2.5 bit times late, then error signal
		acc(1'b1, 8'h04, 32'h05);
		rd(8'h00, 32'h84);
		acc(1'b1, 8'h00, 32'h7e);
		peer.tx_pulse(4'h9);
		peer.tx_pulse(4'h5);
		rd(8'h00, 32'h80);
		repeat (12) @(posedge CLK);
		rd(8'h00, 32'h84);
		peer.tx_pulse(4'h2);
		rd(8'h00, 32'h94);
		acc(1'b1, 8'h04, 32'h04);
		rd(8'h00, 32'h94);
		acc(1'b1, 8'h00, 32'hee);
		rd(8'h00, 32'h84);
		// Multiprocessor bits
		acc(1'b1, 8'h04, 32'h23);
		acc(1'b1, 8'h00, 32'hff);
		@(posedge CLK);
		chk({30'h0, TX_MPB_USE, TX_MPB}, 32'h3);
		peer.send_char(8'h7e, 1'b0, 2'b11, 1'b1);
		rd(8'h00, 32'hc7);
		acc(1'b1, 8'h04, 32'h21);
		rd(8'h00, 32'hc7);
		// Byte strobes: only the low bit-time byte is written
		S_AXI_WSTRB <= 4'h1;
		acc(1'b1, 8'h08, 32'h1234);
		S_AXI_WSTRB <= 4'hf;
		rd(8'h08, 32'h34);
		// Standby restores the status reset image
		STANDBY <= 1'b1;
		repeat (2) @(posedge CLK);
		STANDBY <= 1'b0;
		@(posedge CLK);
		rd(8'h00, 32'h84);
		tally_and_finish;
	end
endmodule
